// ===== bench/mss_client.sv
/*
  Client model for the far side of the server's serial byte port.
  Assumes the bench calls xfer and crc16 and owns the request contents.
*/
`default_nettype none

module mss_client
  import mss_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic [7:0] tx_byte,
  input  wire logic       tx_valid,
  output logic      [7:0] rx_byte,
  output logic            rx_valid,
  output logic            rx_end,
  output logic            tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;

  logic [7:0] rsp [0:15];
  int         rsp_n = 0;

  initial begin
    rx_byte = 8'h00;
    rx_valid = 1'b0;
    rx_end = 1'b0;
    tx_ready = 1'b0;
  end

  // ****************************************
  // Frame send and answer capture
  // ****************************************
  function automatic logic [15:0] crc16(input logic [63:0] fr, input int n);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n; i++) begin
      c = c ^ {8'h00, fr[63-8*i -: 8]};
      for (int k = 0; k < 8; k++) begin
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
      end
    end
    return c;
  endfunction : crc16

  // Eight whole bytes, CRC high byte leads
  task automatic xfer(input logic [63:0] fr, input logic slow);
    rsp_n = 0;
    // No frame goes out while the server is held in reset
    wait (!rst);
    for (int i = 0; i < 8; i++) begin
      @(posedge core_clk);
      rx_byte <= fr[63-8*i -: 8];
      rx_valid <= 1'b1;
      @(posedge core_clk);
      // Released line shows the inverse, never the stale byte
      rx_byte <= ~fr[63-8*i -: 8];
      rx_valid <= 1'b0;
    end
    @(posedge core_clk);
    rx_end <= 1'b1;
    @(posedge core_clk);
    rx_end <= 1'b0;
    for (int c = 0; c < 60; c++) begin
      tx_ready <= slow ? c[1] : 1'b1;
      @(negedge core_clk);
      if (tx_valid && tx_ready) begin
        rsp[rsp_n] = tx_byte;
        rsp_n++;
      end
      @(posedge core_clk);
    end
    tx_ready <= 1'b0;
  endtask : xfer

endmodule : mss_client

`default_nettype wire

// ===== bench/mss_server_test.sv
/*
  Self-checking bench for the status/control server.
  Assumes mss_pkg, mss_crc, mss_server and mss_client compile first.
*/
`default_nettype none

`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); fail_count++; end end

module mss_server_test;
  timeunit 1ns;
  timeprecision 1ns;
  import mss_pkg::*;

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  cfg_addr = 8'h01;
  logic [7:0]  mix_sum = 8'h64;
  logic [3:0]  alarm_hit = 4'h0, limit_set = 4'h0, zcal_state = 4'h0;
  logic [15:0] sim_value = 16'h0000;
  logic        power_up = 1'b0, sensor_range_err = 1'b0, settings_err = 1'b0;
  logic        pulse_range_err = 1'b0, analog_range_err = 1'b0, busy = 1'b0;
  logic        param_crc_err = 1'b0, param_crc_reset = 1'b0, total_err = 1'b0;
  logic        pulse_hw = 1'b0, ce = 1'b1;
  wire  [7:0]  rx_byte, tx_byte;
  wire         rx_valid, rx_end, tx_ready, tx_valid, total_clear;
  int          fail_count = 0, tests_run = 0, clr_n = 0;

  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) if (total_clear === 1'b1) clr_n++;

  mss_server dut_u (.core_clk, .rst, .ce, .cfg_addr, .power_up, .alarm_hit,
    .limit_set, .sensor_range_err, .mix_sum, .settings_err, .sim_value,
    .pulse_range_err, .analog_range_err, .param_crc_err, .param_crc_reset,
    .total_err, .pulse_hw, .busy, .zcal_state, .rx_byte, .rx_valid, .rx_end,
    .tx_ready, .tx_byte, .tx_valid, .total_clear);

  mss_client client_u (.core_clk, .rst, .tx_byte, .tx_valid, .rx_byte, .rx_valid,
    .rx_end, .tx_ready);

  // ****************************************
  // Shared helpers
  // ****************************************
  task automatic end_sim();
    $display("Checks %0d, errors %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : end_sim

  task automatic do_reset();
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask : do_reset

  task automatic req(input logic [7:0] a, f, input logic [15:0] r, d,
                     input logic slow = 1'b0, input logic [7:0] bad = 8'h00);
    logic [47:0] b;
    logic [15:0] c;
    b = {a, f, r, d};
    c = client_u.crc16({b, 16'h0000}, 6);
    client_u.xfer({b, c[15:8] ^ bad, c[7:0]}, slow);
  endtask : req

  task automatic exp(input logic [63:0] b, input int n);
    logic [15:0] c;
    c = client_u.crc16(b, n);
    `CHK(client_u.rsp_n, n + 2)
    for (int i = 0; i < n; i++) `CHK(client_u.rsp[i], b[63-8*i -: 8])
    `CHK(client_u.rsp[n], c[15:8])
    `CHK(client_u.rsp[n+1], c[7:0])
  endtask : exp

  function automatic logic [15:0] pri(input logic c14, t15);
    return {t15, c14, 3'b000, analog_range_err, pulse_range_err,
            sim_value != 16'h0000, settings_err, mix_sum != 8'h64,
            sensor_range_err, alarm_hit & limit_set, power_up};
  endfunction : pri

  task automatic rd_pri(input logic c14, t15);
    req(8'h01, 8'h04, 16'h0000, 16'h0001);
    exp({24'h010402, pri(c14, t15), 24'h000000}, 5);
  endtask : rd_pri

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_status();
    logic [15:0] p, s;
    logic        x;
    for (int k = 0; k < 2; k++) begin
      x = (k == 0);
      @(posedge core_clk);
      power_up <= x;
      alarm_hit <= 4'hF;
      limit_set <= x ? 4'hF : 4'h5;
      sensor_range_err <= x;
      mix_sum <= x ? 8'h63 : 8'h64;
      settings_err <= x;
      sim_value <= x ? 16'h8000 : 16'h0000;
      pulse_range_err <= x;
      analog_range_err <= x;
      pulse_hw <= x;
      busy <= ~x;
      zcal_state <= x ? 4'hA : 4'h5;
      repeat (2) @(posedge core_clk);
      p = pri(1'b0, 1'b0);
      s = {8'h00, zcal_state, 2'b00, busy, pulse_hw};
      req(8'h01, 8'h04, 16'h0000, 16'h0001, x);
      exp({24'h010402, p, 24'h000000}, 5);
      req(8'h01, 8'h04, 16'h0001, 16'h0001);
      exp({24'h010402, s, 24'h000000}, 5);
      req(8'h01, 8'h03, 16'h000F, 16'h0001, 1'b1);
      exp({24'h010302, p, 24'h000000}, 5);
      req(8'h01, 8'h04, 16'h0000, 16'h0002);
      exp({24'h010404, p, s, 8'h00}, 7);
    end
  endtask : t_status

  task automatic t_sticky();
    int n;
    @(posedge core_clk);
    param_crc_err <= 1'b1;
    total_err <= 1'b1;
    @(posedge core_clk);
    param_crc_err <= 1'b0;
    total_err <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd_pri(1'b1, 1'b1);
    param_crc_reset <= 1'b1;
    @(posedge core_clk);
    param_crc_reset <= 1'b0;
    repeat (2) @(posedge core_clk);
    rd_pri(1'b0, 1'b1);
    n = clr_n;
    // Other data is echoed but must not clear anything
    req(8'h01, 8'h06, 16'h0011, 16'h0003);
    exp({48'h010600110003, 16'h0000}, 6);
    `CHK(clr_n, n)
    rd_pri(1'b0, 1'b1);
    req(8'h01, 8'h06, 16'h0011, 16'h0002, 1'b1);
    exp({48'h010600110002, 16'h0000}, 6);
    `CHK(clr_n, n + 1)
    rd_pri(1'b0, 1'b0);
  endtask : t_sticky

  // Error pulses while the clock enable is low must leave no trace
  task automatic t_freeze();
    @(posedge core_clk);
    ce <= 1'b0;
    total_err <= 1'b1;
    param_crc_err <= 1'b1;
    @(posedge core_clk);
    total_err <= 1'b0;
    param_crc_err <= 1'b0;
    @(posedge core_clk);
    ce <= 1'b1;
    repeat (2) @(posedge core_clk);
    rd_pri(1'b0, 1'b0);
  endtask : t_freeze

  task automatic t_drop();
    req(8'h01, 8'h04, 16'h0000, 16'h0001, 1'b0, 8'h01);
    `CHK(client_u.rsp_n, 0)
    req(8'h02, 8'h04, 16'h0000, 16'h0001);
    `CHK(client_u.rsp_n, 0)
    req(8'h01, 8'h05, 16'h0000, 16'h0001);
    exp({24'h018501, 40'h0}, 3);
    req(8'h01, 8'h04, 16'h0005, 16'h0001);
    exp({24'h018402, 40'h0}, 3);
  endtask : t_drop

  task automatic t_addr();
    logic [7:0] a [3] = '{8'h05, 8'hF7, 8'hF8};
    @(posedge core_clk);
    cfg_addr <= 8'h05;
    req(8'h05, 8'h04, 16'h0001, 16'h0001);
    `CHK(client_u.rsp_n, 0)
    req(8'h01, 8'h04, 16'h0001, 16'h0001);
    `CHK(client_u.rsp_n, 7)
    for (int i = 0; i < 3; i++) begin
      cfg_addr <= a[i];
      do_reset();
      req(a[i], 8'h04, 16'h0001, 16'h0001);
      `CHK(client_u.rsp_n, (i == 2) ? 0 : 7)
    end
  endtask : t_addr

  initial begin
    do_reset();
    t_status();
    t_sticky();
    t_freeze();
    t_drop();
    t_addr();
    end_sim();
  end

  // Whole run needs about 2000 cycles
  initial begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    end_sim();
  end

endmodule : mss_server_test

`default_nettype wire

// ===== hw/mss_crc.sv
/*
  Byte-serial CRC-16 engine (reflected polynomial, all-ones start).
  Assumes clr and step come from logic on the same clock; clr wins.
*/
`default_nettype none

module mss_crc
  import mss_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic        clr,
  input  wire logic        step,
  input  wire logic [7:0]  data,
  output logic      [15:0] crc
);

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction : crc_byte

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      crc <= CRC_INIT;
    end else if (ce) begin
      if (clr) begin
        crc <= CRC_INIT;
      end else if (step) begin
        crc <= crc_byte(crc, data);
      end
    end
  end

endmodule : mss_crc

`default_nettype wire

// ===== hw/mss_pkg.sv
/*
  Shared constants for the serial status/control server: function codes,
  register addresses, status bit positions, CRC settings and FSM states.
  Assumes it is compiled before every other design file.
*/
`default_nettype none

package mss_pkg;

  // ****************************************
  // Frame fields
  // ****************************************
  localparam logic [7:0]  FN_RD_HOLD       = 8'h03;
  localparam logic [7:0]  FN_RD_INPUT      = 8'h04;
  localparam logic [7:0]  FN_WR_SINGLE     = 8'h06;
  localparam logic [7:0]  EXC_FLAG         = 8'h80;
  localparam logic [7:0]  EXC_BAD_FN       = 8'h01;
  localparam logic [7:0]  EXC_BAD_ADDR     = 8'h02;
  localparam logic [3:0]  REQ_LEN          = 4'h8;
  localparam logic [3:0]  REQ_BODY_LEN     = 4'h6;
  localparam logic [3:0]  RSP_EXC_LEN      = 4'h3;
  localparam logic [3:0]  RSP_ONE_LEN      = 4'h5;
  localparam logic [3:0]  RSP_TWO_LEN      = 4'h7;
  localparam logic [3:0]  RSP_ECHO_LEN     = 4'h6;
  localparam logic [3:0]  CRC_BYTES        = 4'h2;

  // ****************************************
  // Register addresses and values
  // ****************************************
  localparam logic [15:0] IREG_PRI         = 16'h0000;
  localparam logic [15:0] IREG_SEC         = 16'h0001;
  localparam logic [15:0] HREG_PRI         = 16'h000F;
  localparam logic [15:0] HREG_SEC         = 16'h0010;
  localparam logic [15:0] REG_CONTROL      = 16'h0011;
  localparam logic [15:0] CTRL_RESET_TOTAL = 16'h0002;
  localparam logic [15:0] CNT_ONE          = 16'h0001;
  localparam logic [15:0] CNT_TWO          = 16'h0002;
  localparam logic [15:0] STATUS_RESET     = 16'h0000;
  localparam logic [7:0]  ADDR_MIN         = 8'h01;
  localparam logic [7:0]  ADDR_MAX         = 8'hF7;
  localparam logic [7:0]  MIX_FULL_PCT     = 8'h64;

  // ****************************************
  // Status bit positions
  // ****************************************
  localparam int PRI_POWERUP   = 0;
  localparam int PRI_ALARM_LO  = 1;
  localparam int PRI_ALARM_HI  = 4;
  localparam int PRI_SENSOR    = 5;
  localparam int PRI_MIX       = 6;
  localparam int PRI_SETTINGS  = 7;
  localparam int PRI_SIM       = 8;
  localparam int PRI_PULSE     = 9;
  localparam int PRI_ANALOG    = 10;
  localparam int PRI_PARAM_CRC = 14;
  localparam int PRI_TOTAL     = 15;
  localparam int SEC_PULSE_HW  = 0;
  localparam int SEC_BUSY      = 1;
  localparam int SEC_ZCAL_LO   = 4;
  localparam int SEC_ZCAL_HI   = 7;

  // ****************************************
  // CRC and states
  // ****************************************
  localparam logic [15:0] CRC_INIT         = 16'hFFFF;
  localparam logic [15:0] CRC_POLY         = 16'hA001;

  typedef enum logic [1:0] {
    ST_RX    = 2'b00,
    ST_CHECK = 2'b01,
    ST_TX    = 2'b10
  } mss_state_t;

endpackage : mss_pkg

`default_nettype wire

// ===== hw/mss_server.sv
/*
  Serial-line request/answer server for a flow meter: reads of two status
  words, write of the command register. Assumes a same-clock byte receiver
  giving rx_valid per byte and rx_end after the inter-frame gap, and a
  same-clock byte transmitter taking bytes on tx_valid and tx_ready.
*/
//
// What this block does
// - Status answer: address, 04, count two, data, CRC
// - Bit 0 shows power-up sequence running
// - Bits 1-4 limit alarms, off when limit zero
// - Bit 5 shows sensor reading out of range
// - Bit 6 shows mixture not summing to 100%
// - Bit 8 simulation active, off at value zero
// - Bit 9 shows pulse/alarm output out of range
// - Bit 10 shows analog output out of range
// - Bit 14 parameter CRC error, sticky until reset
// - Bit 15 totalizer error, cleared by total reset
// - Second status: pulse hardware bit 0, busy 1
// - Second status bits 4-7 calibration check states
// - Write 0x02 to 0x11 clears total and time
// - Write answer echoes address, function, register, data
// - Own address 1..247; answer only to it
// - Address change takes effect after power cycle only
// - Only functions 03, 04 and 06 supported
// - Address and function one byte, other fields two; CRC high byte first
`default_nettype none

module mss_server
  import mss_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        ce,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic        power_up,
  input  wire logic [3:0]  alarm_hit,
  input  wire logic [3:0]  limit_set,
  input  wire logic        sensor_range_err,
  input  wire logic [7:0]  mix_sum,
  input  wire logic        settings_err,
  input  wire logic [15:0] sim_value,
  input  wire logic        pulse_range_err,
  input  wire logic        analog_range_err,
  input  wire logic        param_crc_err,
  input  wire logic        param_crc_reset,
  input  wire logic        total_err,
  input  wire logic        pulse_hw,
  input  wire logic        busy,
  input  wire logic [3:0]  zcal_state,
  input  wire logic [7:0]  rx_byte,
  input  wire logic        rx_valid,
  input  wire logic        rx_end,
  input  wire logic        tx_ready,
  output logic      [7:0]  tx_byte,
  output logic             tx_valid,
  output logic             total_clear
);

  // ****************************************
  // State
  // ****************************************
  mss_state_t  state_reg;
  logic [7:0]  rx_buf [0:7];
  logic [3:0]  rx_cnt_reg;
  logic        rx_ovf_reg;
  logic [7:0]  rsp_reg [0:6];
  logic [3:0]  rsp_len_reg;
  logic [3:0]  tx_idx_reg;
  logic [7:0]  addr_reg;
  logic        addr_ok_reg;
  logic        addr_loaded_reg;
  logic [15:0] pri_reg;
  logic [15:0] sec_reg;
  logic        crc_err_reg;
  logic        tot_err_reg;
  logic [15:0] rx_crc;
  logic [15:0] tx_crc;

  // ****************************************
  // Status words
  // ****************************************
  wire         crc_err_next = param_crc_err | (crc_err_reg & ~param_crc_reset);
  wire         tot_err_next = total_err | (tot_err_reg & ~total_clear);
  wire  [3:0]  alarm_live   = alarm_hit & limit_set;
  wire  [15:0] pri_next     = {tot_err_reg,
                               crc_err_reg,
                               3'b000,
                               analog_range_err,
                               pulse_range_err,
                               (sim_value != 16'h0000),
                               settings_err,
                               (mix_sum != MIX_FULL_PCT),
                               sensor_range_err,
                               alarm_live,
                               power_up};
  wire  [15:0] sec_next     = {8'h00, zcal_state, 2'b00, busy, pulse_hw};

  // ****************************************
  // Request decode
  // ****************************************
  wire  [7:0]  fn        = rx_buf[1];
  wire  [15:0] start     = {rx_buf[2], rx_buf[3]};
  wire  [15:0] arg       = {rx_buf[4], rx_buf[5]};
  wire  [15:0] got_crc   = {rx_buf[6], rx_buf[7]};
  wire         cnt_ok    = (arg == CNT_ONE) || (arg == CNT_TWO);
  wire         rd04_ok   = (fn == FN_RD_INPUT) &&
                           (((start == IREG_PRI) && cnt_ok) ||
                            ((start == IREG_SEC) && (arg == CNT_ONE)));
  wire         rd03_ok   = (fn == FN_RD_HOLD) &&
                           (((start == HREG_PRI) && cnt_ok) ||
                            ((start == HREG_SEC) && (arg == CNT_ONE)));
  wire         wr_ok     = (fn == FN_WR_SINGLE) && (start == REG_CONTROL);
  wire         fn_known  = (fn == FN_RD_HOLD) || (fn == FN_RD_INPUT) ||
                           (fn == FN_WR_SINGLE);
  wire         rd_ok     = rd04_ok || rd03_ok;
  wire         first_sec = (fn == FN_RD_INPUT) ? start[0] : (start == HREG_SEC);
  wire  [15:0] word0     = first_sec ? sec_reg : pri_reg;
  wire         two_words = (arg == CNT_TWO);
  wire         frame_ok  = (rx_cnt_reg == REQ_LEN) && !rx_ovf_reg && addr_ok_reg &&
                           (rx_buf[0] == addr_reg) && (got_crc == rx_crc);
  wire         do_clear  = frame_ok && wr_ok && (arg == CTRL_RESET_TOTAL);

  // ****************************************
  // Answer build
  // ****************************************
  wire  [7:0]  rsp_next [0:6];
  assign rsp_next[0] = addr_reg;
  assign rsp_next[1] = (rd_ok || wr_ok) ? fn : (fn | EXC_FLAG);
  assign rsp_next[2] = rd_ok ? {arg[6:0], 1'b0} :
                       wr_ok ? rx_buf[2] :
                       (fn_known ? EXC_BAD_ADDR : EXC_BAD_FN);
  assign rsp_next[3] = rd_ok ? word0[15:8] : rx_buf[3];
  assign rsp_next[4] = rd_ok ? word0[7:0] : rx_buf[4];
  assign rsp_next[5] = rd_ok ? sec_reg[15:8] : rx_buf[5];
  assign rsp_next[6] = sec_reg[7:0];
  wire  [3:0]  rsp_len_next = rd_ok ? (two_words ? RSP_TWO_LEN : RSP_ONE_LEN) :
                              wr_ok ? RSP_ECHO_LEN : RSP_EXC_LEN;

  // ****************************************
  // Transmit select
  // ****************************************
  wire         tx_take  = (state_reg == ST_TX) && (!tx_valid || tx_ready);
  wire         tx_more  = tx_idx_reg < 4'(rsp_len_reg + CRC_BYTES);
  wire         tx_body  = tx_idx_reg < rsp_len_reg;
  wire  [7:0]  tx_data  = tx_body ? rsp_reg[tx_idx_reg[2:0]] :
                          (tx_idx_reg == rsp_len_reg) ? tx_crc[15:8] : tx_crc[7:0];
  wire         rx_take  = (state_reg == ST_RX) && rx_valid;
  wire         crc_clr  = (state_reg == ST_CHECK);

  mss_crc u_rx_crc (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .clr      (crc_clr),
    .step     (rx_take && (rx_cnt_reg < REQ_BODY_LEN)),
    .data     (rx_byte),
    .crc      (rx_crc)
  );

  mss_crc u_tx_crc (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (ce),
    .clr      (crc_clr),
    .step     (tx_take && tx_body),
    .data     (tx_data),
    .crc      (tx_crc)
  );

  // ****************************************
  // Address, caught once after reset
  // ****************************************
  // Later changes on cfg_addr are ignored until the next reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_loaded_reg <= 1'b0;
      addr_reg        <= 8'h00;
      addr_ok_reg     <= 1'b0;
    end else if (ce && !addr_loaded_reg) begin
      addr_loaded_reg <= 1'b1;
      addr_reg        <= cfg_addr;
      addr_ok_reg     <= (cfg_addr >= ADDR_MIN) && (cfg_addr <= ADDR_MAX);
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pri_reg     <= STATUS_RESET;
      sec_reg     <= STATUS_RESET;
      crc_err_reg <= 1'b0;
      tot_err_reg <= 1'b0;
    end else if (ce) begin
      pri_reg     <= pri_next;
      sec_reg     <= sec_next;
      crc_err_reg <= crc_err_next;
      tot_err_reg <= tot_err_next;
    end
  end

  // ****************************************
  // Receive buffer
  // ****************************************
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_cnt_reg <= 4'h0;
      rx_ovf_reg <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        rx_buf[i] <= 8'h00;
      end
    end else if (ce) begin
      if (crc_clr) begin
        rx_cnt_reg <= 4'h0;
        rx_ovf_reg <= 1'b0;
      end else if (rx_take) begin
        if (rx_cnt_reg < REQ_LEN) begin
          rx_buf[rx_cnt_reg[2:0]] <= rx_byte;
          rx_cnt_reg              <= 4'(rx_cnt_reg + 4'h1);
        end else begin
          rx_ovf_reg <= 1'b1;
        end
      end
    end
  end

  // ****************************************
  // Sequencer
  // ****************************************
  // Half duplex: bytes arriving while an answer is out are dropped
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg   <= ST_RX;
      rsp_len_reg <= 4'h0;
      tx_idx_reg  <= 4'h0;
      total_clear <= 1'b0;
      for (int i = 0; i < 7; i++) begin
        rsp_reg[i] <= 8'h00;
      end
    end else if (ce) begin
      total_clear <= 1'b0;
      unique case (state_reg)
        ST_RX: begin
          if (rx_end) begin
            state_reg <= ST_CHECK;
          end
        end
        ST_CHECK: begin
          tx_idx_reg  <= 4'h0;
          rsp_len_reg <= rsp_len_next;
          for (int i = 0; i < 7; i++) begin
            rsp_reg[i] <= rsp_next[i];
          end
          total_clear <= do_clear;
          state_reg   <= frame_ok ? ST_TX : ST_RX;
        end
        ST_TX: begin
          if (tx_take) begin
            if (tx_more) begin
              tx_idx_reg <= 4'(tx_idx_reg + 4'h1);
            end else begin
              state_reg <= ST_RX;
            end
          end
        end
        default: begin
          state_reg <= ST_RX;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      tx_valid <= 1'b0;
      tx_byte  <= 8'h00;
    end else if (ce && tx_take) begin
      tx_valid <= tx_more;
      if (tx_more) begin
        tx_byte <= tx_data;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  power_bit_a: assert property (@(posedge core_clk) disable iff (rst || !ce)
    ce && $past(ce) && !$past(rst) |-> pri_reg[PRI_POWERUP] == $past(power_up))
    else $error("power-up bit does not follow sequence");

  limit_gate_a: assert property (@(posedge core_clk) disable iff (rst || !ce)
    $past(limit_set) == 4'h0 && $past(ce) |-> pri_reg[PRI_ALARM_HI:PRI_ALARM_LO] == 4'h0)
    else $error("alarm flag set with limit zero");

  sim_flag_a: assert property (@(posedge core_clk) disable iff (rst || !ce)
    $past(ce) && !$past(rst) |-> pri_reg[PRI_SIM] == ($past(sim_value) != 16'h0000))
    else $error("simulation bit wrong");

  crc_sticky_a: assert property (@(posedge core_clk) disable iff (rst || !ce)
    crc_err_reg && !param_crc_reset |=> crc_err_reg)
    else $error("parameter CRC flag dropped without reset");

  total_fall_a: assert property (@(posedge core_clk) disable iff (rst || !ce)
    $fell(tot_err_reg) |-> $past(total_clear))
    else $error("total error cleared without total reset");

  unused_zero_a: assert property (@(posedge core_clk) disable iff (rst)
    pri_reg[13:11] == 3'b000 && sec_reg[15:8] == 8'h00 && sec_reg[3:2] == 2'b00)
    else $error("unused status bit set");

  drop_bad_a: assert property (@(posedge core_clk) disable iff (rst || !ce)
    state_reg == ST_CHECK && !frame_ok |=> state_reg == ST_RX && !tx_valid)
    else $error("answer started for rejected frame");

  first_byte_a: assert property (@(posedge core_clk) disable iff (rst || !ce)
    state_reg == ST_CHECK && frame_ok |=> ##1 tx_valid && tx_byte == addr_reg)
    else $error("answer does not open with own address");

  clear_pulse_a: assert property (@(posedge core_clk) disable iff (rst || !ce)
    total_clear |-> $past(state_reg) == ST_CHECK ##1 !total_clear)
    else $error("total clear not a single pulse after a write");

  addr_hold_a: assert property (@(posedge core_clk) disable iff (rst || !ce)
    addr_loaded_reg |=> $stable(addr_reg))
    else $error("address changed without reset");

endmodule : mss_server

`default_nettype wire
